// *** core/sec_port_rx_timing.sv ***
// Purpose: secondary audio port channel 8 output and receive timing control
// Assumes: link pins are asynchronous and pass two flops before use
// Notes: captures slot 0 of both data pins, slots are 32 bits wide
`timescale 1ns/1ps
`include "sec_port_params.svh"

module sec_port_rx_timing (
    // clock, reset, enable
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic i_ce,
    // register port
    input wire logic i_reg_wr,
    input wire logic [7:0] i_reg_addr,
    input wire logic [7:0] i_reg_wdata,
    output logic [7:0] o_reg_rdata,
    // port configuration
    input wire logic i_controller_mode,
    input wire logic i_bit_clock_polarity,
    input wire sec_port_pkg::fmt_t i_fmt,
    // serial link pins
    input wire logic i_bclk,
    input wire logic i_fsync,
    input wire logic i_din,
    input wire logic i_din2,
    output logic o_dout,
    output logic o_dout_oe,
    output logic o_bclk_int,
    output logic o_fsync_int,
    // channel 8 source word
    input wire logic [31:0] i_cross_device_link_data,
    // captured slot 0 words
    output logic o_rx_valid,
    output sec_port_pkg::rx_word_t o_rx_word,
    input wire logic i_rx_ready,
    output logic o_overrun
);
    sec_port_pkg::state_t s_r;
    sec_port_pkg::state_t s_nxt;
    logic fifo_ready;
    logic bclk_sel;
    logic fs_sel;
    logic samp;
    logic drive;
    logic on_rise;
    logic start_l;
    logic start_r;
    logic [9:0] cur;
    logic [9:0] tpos;
    logic [9:0] off_lo;
    logic [9:0] off_hi;
    logic complete;
    logic [4:0] slot_id;

    function automatic logic hit(input logic [7:0] a, input logic [7:0] want);
        hit = (a == want);
    endfunction

    always_comb begin
        s_nxt = s_r;
        // pins: the first stage feeds only the second
        s_nxt.s1 = {i_bclk, i_fsync, i_din, i_din2};
        s_nxt.s2 = s_r.s1;
        // internal clocks, used only when controlling the link
        if (s_r.div_cnt == 8'(`BCLK_HALF_CYC - 1)) begin
            s_nxt.div_cnt = 8'h00;
            s_nxt.bclk_int = !s_r.bclk_int;
            if (s_r.bclk_int) begin
                s_nxt.fcnt = (s_r.fcnt == 7'(`FRAME_BITS - 1)) ? 7'h00 : s_r.fcnt + 7'h01;
                s_nxt.fsync_int = (s_nxt.fcnt < 7'(`FRAME_BITS / 2));
            end
        end else begin
            s_nxt.div_cnt = s_r.div_cnt + 8'h01;
        end
        bclk_sel = (i_controller_mode && s_r.rx_cfg.int_bclk) ? s_r.bclk_int : s_r.s2[3];
        fs_sel = (i_controller_mode && s_r.rx_cfg.int_fs) ? s_r.fsync_int : s_r.s2[2];
        s_nxt.bclk_prev = bclk_sel;
        on_rise = !(i_bit_clock_polarity ^ s_r.rx_cfg.edge_inv);
        samp = on_rise ? (bclk_sel && !s_r.bclk_prev) : (!bclk_sel && s_r.bclk_prev);
        drive = on_rise ? (!bclk_sel && s_r.bclk_prev) : (bclk_sel && !s_r.bclk_prev);
        // frame and half starts seen at sampling edges
        if (i_fmt == sec_port_pkg::FMT_I2S) begin
            start_l = !fs_sel && s_r.fs_at_samp;
            start_r = fs_sel && !s_r.fs_at_samp;
        end else begin
            start_l = fs_sel && !s_r.fs_at_samp;
            start_r = (i_fmt == sec_port_pkg::FMT_LJ) && !fs_sel && s_r.fs_at_samp;
        end
        // i2s puts the msb one bit clock after the frame sync edge
        if (start_l || start_r) begin
            cur = (i_fmt == sec_port_pkg::FMT_I2S) ? 10'h3ff : 10'h000;
        end else begin
            cur = s_r.pos + 10'h001;
        end
        off_lo = {5'h00, s_r.rx_cfg.offset};
        off_hi = off_lo + 10'(`SLOT_BITS - 1);
        complete = samp && (cur == off_hi);
        if (samp) begin
            s_nxt.fs_at_samp = fs_sel;
            s_nxt.pos = cur;
            if (start_l || start_r) begin
                s_nxt.half = start_r;
            end
            // slot 0 in every half, shifted msb first
            if (cur != 10'h3ff && cur >= off_lo && cur <= off_hi) begin
                s_nxt.sh1 = {s_r.sh1[30:0], s_r.s2[1]};
                s_nxt.sh2 = {s_r.sh2[30:0], s_r.s2[0]};
            end
        end
        // one pending word rides out fifo back-pressure; a second one is lost
        if (s_r.pend_v && fifo_ready) begin
            s_nxt.pend_v = 1'b0;
        end
        if (complete) begin
            if (s_r.pend_v && !fifo_ready) begin
                s_nxt.overrun = 1'b1;
            end else begin
                s_nxt.pend_v = 1'b1;
                s_nxt.pend.right = s_nxt.half;
                s_nxt.pend.d1 = {s_r.sh1[30:0], s_r.s2[1]};
                s_nxt.pend.d2 = {s_r.sh2[30:0], s_r.s2[0]};
            end
        end
        // channel 8 transmit, launched half a bit ahead of the far end's sampling
        tpos = s_r.pos + 10'h001;
        if (i_fmt == sec_port_pkg::FMT_TDM) begin
            slot_id = tpos[9:5];
        end else begin
            slot_id = {s_r.half, tpos[8:5]};
        end
        if (drive) begin
            s_nxt.tx_slot_seen = slot_id;
            s_nxt.dout_oe = s_r.tx_cfg.src && (slot_id == s_r.tx_cfg.slot)
                && (i_fmt == sec_port_pkg::FMT_TDM || tpos[9] == 1'b0);
            s_nxt.dout = i_cross_device_link_data[5'h1f - tpos[4:0]];
        end
        if (!s_r.tx_cfg.src) begin
            s_nxt.dout_oe = 1'b0;
        end
        // register port
        if (i_reg_wr && hit(i_reg_addr, `TXCFG_ADDR)) begin
            s_nxt.tx_cfg = {2'b00, i_reg_wdata[`TXCFG_SRC_BIT:0]};
        end
        if (i_reg_wr && hit(i_reg_addr, `RXCFG_ADDR)) begin
            s_nxt.rx_cfg = i_reg_wdata;
        end
        if (hit(i_reg_addr, `TXCFG_ADDR)) begin
            s_nxt.rdata = s_r.tx_cfg;
        end else if (hit(i_reg_addr, `RXCFG_ADDR)) begin
            s_nxt.rdata = s_r.rx_cfg;
        end else begin
            s_nxt.rdata = 8'h00;
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            s_r <= '0;
            s_r.tx_cfg <= `TXCFG_RST;
            s_r.rx_cfg <= `RXCFG_RST;
        end else if (i_ce) begin
            s_r <= s_nxt;
        end
    end

    sample_fifo #(
        .WIDTH($bits(sec_port_pkg::rx_word_t)),
        .DEPTH(`FIFO_DEPTH)
    ) u_fifo (
        .i_clk(i_clk),
        .i_rst(i_rst),
        .i_ce(i_ce),
        .i_in_valid(s_r.pend_v),
        .i_in_data(s_r.pend),
        .o_in_ready(fifo_ready),
        .o_out_valid(o_rx_valid),
        .o_out_data(o_rx_word),
        .i_out_ready(i_rx_ready)
    );

    assign o_reg_rdata = s_r.rdata;
    assign o_dout = s_r.dout;
    assign o_dout_oe = s_r.dout_oe;
    assign o_bclk_int = s_r.bclk_int;
    assign o_fsync_int = s_r.fsync_int;
    assign o_overrun = s_r.overrun;

    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_rst);

    rsvd_read_zero_a: assert property (
        $past(i_ce) && hit($past(i_reg_addr), `TXCFG_ADDR) |-> o_reg_rdata[7:6] == 2'b00)
        else $error("reserved bits of channel 8 config read nonzero");
    src_off_hiz_a: assert property (
        i_ce && !s_r.tx_cfg.src |=> !o_dout_oe)
        else $error("channel 8 driven while its source is off");
    slot_match_a: assert property (
        o_dout_oe |-> s_r.tx_slot_seen == s_r.tx_cfg.slot && s_r.tx_cfg.src)
        else $error("channel 8 driven outside its slot");
    sample_edge_a: assert property (
        i_ce && samp |-> bclk_sel != (i_bit_clock_polarity ^ s_r.rx_cfg.edge_inv)
        && s_r.bclk_prev == (i_bit_clock_polarity ^ s_r.rx_cfg.edge_inv))
        else $error("data sampled on the wrong bit clock edge");
    int_fsync_use_a: assert property (
        i_controller_mode && s_r.rx_cfg.int_fs |-> fs_sel == s_r.fsync_int)
        else $error("internal frame sync not used when selected");
    int_bclk_use_a: assert property (
        !(i_controller_mode && s_r.rx_cfg.int_bclk) |-> bclk_sel == s_r.s2[3])
        else $error("external bit clock not used when selected");
    offset_word_a: assert property (
        i_ce && complete && !(s_r.pend_v && !fifo_ready)
        |-> cur == {5'h00, s_r.rx_cfg.offset} + 10'h01f ##1 s_r.pend_v)
        else $error("slot 0 word not completed at offset plus 31");

    tx_drive_c: cover property (s_r.tx_cfg.src && o_dout_oe);
    word_done_c: cover property (i_ce && complete && s_r.rx_cfg.offset != 5'h00);
    overrun_c: cover property (!o_overrun ##1 o_overrun);
endmodule

// *** shared/sec_port_params.svh ***
// Purpose: constants for the secondary audio port receive timing block
// Assumes: 50 MHz core clock, 32-bit slots
// Notes: addresses are the register map offsets on the control port
`ifndef SEC_PORT_PARAMS_SVH
`define SEC_PORT_PARAMS_SVH

`define TXCFG_ADDR 8'h25
`define RXCFG_ADDR 8'h26
`define TXCFG_RST 8'h07
`define RXCFG_RST 8'h00
`define TXCFG_RSVD_HI 7
`define TXCFG_RSVD_LO 6
`define TXCFG_SRC_BIT 5
`define RXCFG_EDGE_BIT 7
`define RXCFG_INT_FS_BIT 6
`define RXCFG_INT_BCLK_BIT 5
`define FIELD_LO_MSB 4
`define CLK_MHZ 50
`define BCLK_HALF_NS 80
`define BCLK_HALF_CYC ((`BCLK_HALF_NS * `CLK_MHZ + 999) / 1000)
`define SLOT_BITS 32
`define FRAME_BITS 64
`define FIFO_DEPTH 16

`endif

// *** shared/sec_port_pkg.sv ***
// Purpose: types for the secondary audio port receive timing block
// Assumes: 32-bit slots on both data pins
// Notes: constants live in sec_port_params.svh
package sec_port_pkg;

    typedef enum logic [1:0] {
        FMT_TDM,
        FMT_I2S,
        FMT_LJ
    } fmt_t;

    typedef struct packed {
        logic [1:0] rsvd;
        logic src;
        logic [4:0] slot;
    } tx_cfg_t;

    typedef struct packed {
        logic edge_inv;
        logic int_fs;
        logic int_bclk;
        logic [4:0] offset;
    } rx_cfg_t;

    typedef struct packed {
        logic right;
        logic [31:0] d1;
        logic [31:0] d2;
    } rx_word_t;

    typedef struct packed {
        logic [3:0] s1;
        logic [3:0] s2;
        logic bclk_prev;
        logic fs_at_samp;
        logic [7:0] div_cnt;
        logic bclk_int;
        logic [6:0] fcnt;
        logic fsync_int;
        logic [9:0] pos;
        logic half;
        logic [31:0] sh1;
        logic [31:0] sh2;
        logic pend_v;
        rx_word_t pend;
        logic overrun;
        logic dout;
        logic dout_oe;
        logic [4:0] tx_slot_seen;
        logic [7:0] rdata;
        tx_cfg_t tx_cfg;
        rx_cfg_t rx_cfg;
    } state_t;

endpackage

// *** core/sample_fifo.sv ***
// Purpose: flop-based first-in first-out buffer for captured slot words
// Assumes: single clock, push and pop may share a cycle
// Notes: out_data is the head entry, valid while out_valid is high
`timescale 1ns/1ps
module sample_fifo #(
    parameter int WIDTH = 65,
    parameter int DEPTH = 16
) (
    // clock, reset and enable
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic i_ce,
    // fill side
    input wire logic i_in_valid,
    input wire logic [WIDTH-1:0] i_in_data,
    output logic o_in_ready,
    // drain side
    output logic o_out_valid,
    output logic [WIDTH-1:0] o_out_data,
    input wire logic i_out_ready
);
    localparam int AW = $clog2(DEPTH);

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [AW:0] wp;
        logic [AW:0] rp;
    } fifo_st_t;

    fifo_st_t f_r;
    fifo_st_t f_nxt;
    logic full;
    logic empty;

    always_comb begin
        full = (f_r.wp[AW] != f_r.rp[AW]) && (f_r.wp[AW-1:0] == f_r.rp[AW-1:0]);
        empty = (f_r.wp == f_r.rp);
        f_nxt = f_r;
        if (i_in_valid && !full) begin
            f_nxt.mem[f_r.wp[AW-1:0]] = i_in_data;
            f_nxt.wp = f_r.wp + 1'b1;
        end
        if (i_out_ready && !empty) begin
            f_nxt.rp = f_r.rp + 1'b1;
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            f_r <= '0;
        end else if (i_ce) begin
            f_r <= f_nxt;
        end
    end

    assign o_in_ready = !full;
    assign o_out_valid = !empty;
    assign o_out_data = f_r.mem[f_r.rp[AW-1:0]];
endmodule

// *** bench/host_link_model.sv ***
// Purpose: host end of the secondary audio link, drives clocks and data
// Assumes: bit clock period 160 ns, clock stands still between frames
// Notes: idle data lines toggle so a stale bit never passes for a match
`timescale 1ns/1ps
module host_link_model (
    // link pins towards the block
    output logic o_bclk,
    output logic o_fsync,
    output logic o_din,
    output logic o_din2,
    // channel 8 return
    input wire logic i_dout,
    input wire logic i_dout_oe
);
    logic [143:0] got_d;
    logic [143:0] got_oe;
    initial begin
        o_bclk = 1'b0;
        o_fsync = 1'b0;
        o_din = 1'b0;
        o_din2 = 1'b1;
    end
    task automatic hold(input logic a, input logic b);
        o_din = a;
        o_din2 = b;
    endtask
    // lj sends two halves of hlen bits, otherwise one tdm frame of hlen bits;
    // lead pushes the msb one more bit late, as i2s framing does
    task automatic send_frame(input logic lj, input int hlen, input int off,
            input logic inv, input logic [31:0] w1, input logic [31:0] w2, input int lead);
        int j;
        logic h;
        o_bclk = inv;
        for (int k = 0; k < (lj ? 2 * hlen : hlen); k++) begin
            h = (k >= hlen);
            j = h ? k - hlen : k;
            o_fsync = lj ? !h : (k == 0);
            if (j >= off + lead && j < off + lead + 32) begin
                o_din = w1[31 + off + lead - j] ^ h;
                o_din2 = w2[31 + off + lead - j] ^ h;
            end else begin
                o_din = ~o_din;
                o_din2 = ~o_din2;
            end
            // data launched on the drive edge, stable across the sample edge
            #80 o_bclk = ~inv;
            #70 got_d[k] = i_dout;
            got_oe[k] = i_dout_oe;
            #10 o_bclk = inv;
        end
        o_fsync = 1'b0;
        o_din = ~o_din;
        o_din2 = ~o_din2;
    endtask
endmodule

// *** bench/tb.sv ***
// Purpose: self-checking bench for channel 8 output and receive timing
// Assumes: host model owns the external link clock
// Notes: fifo fill runs on internal clocks so the host can stay idle
`timescale 1ns/1ps
module tb;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic ce = 1'b1;
    logic reg_wr = 1'b0;
    logic [7:0] reg_addr = 8'h00;
    logic [7:0] reg_wdata = 8'h00;
    logic [7:0] reg_rdata;
    logic ctrl_mode = 1'b0;
    logic pol = 1'b0;
    sec_port_pkg::fmt_t fmt = sec_port_pkg::FMT_TDM;
    logic bclk, fsync, din, din2, dout, dout_oe, bclk_int, fsync_int;
    logic [31:0] link_word = 32'h9E37_79B1;
    logic rx_valid, overrun;
    logic rx_ready = 1'b0;
    sec_port_pkg::rx_word_t rx_word;
    logic [31:0] w1 = 32'hA5C3_0F96;
    logic [31:0] w2 = 32'h5A3C_F069;
    int fails = 0;
    int total_checks = 0;
    always #10 clk = ~clk;
    sec_port_rx_timing i_sec_port_rx_timing (.i_clk(clk), .i_rst(rst), .i_ce(ce),
        .i_reg_wr(reg_wr), .i_reg_addr(reg_addr), .i_reg_wdata(reg_wdata),
        .o_reg_rdata(reg_rdata), .i_controller_mode(ctrl_mode),
        .i_bit_clock_polarity(pol), .i_fmt(fmt), .i_bclk(bclk), .i_fsync(fsync),
        .i_din(din), .i_din2(din2), .o_dout(dout), .o_dout_oe(dout_oe),
        .o_bclk_int(bclk_int), .o_fsync_int(fsync_int),
        .i_cross_device_link_data(link_word), .o_rx_valid(rx_valid),
        .o_rx_word(rx_word), .i_rx_ready(rx_ready), .o_overrun(overrun));
    host_link_model i_host_link_model (.o_bclk(bclk), .o_fsync(fsync), .o_din(din),
        .o_din2(din2), .i_dout(dout), .i_dout_oe(dout_oe));
    task automatic chk(input logic [64:0] got, input logic [64:0] exp);
        total_checks++;
        if (got !== exp) begin
            fails++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk) #1;
        reg_wr = 1'b1;
        reg_addr = a;
        reg_wdata = d;
        @(posedge clk) #1;
        reg_wr = 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, output logic [64:0] d);
        @(posedge clk) #1;
        reg_addr = a;
        @(posedge clk) #1;
        d = {57'h0, reg_rdata};
    endtask
    // waits a bounded time for a captured word, compares and pops it
    task automatic pop(input logic [64:0] exp);
        int n;
        n = 0;
        @(posedge clk) #1;
        while (rx_valid !== 1'b1 && n < 300) begin
            @(posedge clk) #1;
            n++;
        end
        chk(65'(rx_valid), 65'h1);
        chk(rx_word, exp);
        rx_ready = 1'b1;
        @(posedge clk) #1;
        rx_ready = 1'b0;
    endtask
    // bit 0 of a frame cannot be launched early, so the first two bits are skipped
    task automatic chk_tx(input int base, input int n);
        logic s;
        for (int k = 2; k < n; k++) begin
            s = (k >= base) && (k < base + 32);
            chk(65'(i_host_link_model.got_oe[k]), 65'(s));
            if (s)
                chk(65'(i_host_link_model.got_d[k]), 65'(link_word[31 + base - k]));
        end
    endtask
    task automatic t_regs();
        logic [64:0] d;
        rd(8'h25, d);
        chk(d, 65'h07);
        rd(8'h26, d);
        chk(d, 65'h00);
        wr(8'h25, 8'hFF);
        rd(8'h25, d);
        chk(d, 65'h3F);
        wr(8'h27, 8'h5A);
        rd(8'h27, d);
        chk(d, 65'h00);
        wr(8'h26, 8'h9F);
        rd(8'h26, d);
        chk(d, 65'h9F);
        // a write while the enable is low must leave the register untouched
        ce = 1'b0;
        wr(8'h26, 8'h00);
        ce = 1'b1;
        rd(8'h26, d);
        chk(d, 65'h9F);
        $display("t_regs done");
    endtask
    task automatic t_src_off();
        pol = 1'b1;
        wr(8'h25, 8'h01);
        wr(8'h26, 8'h00);
        i_host_link_model.send_frame(1'b0, 64, 0, 1'b1, w1, w2, 0);
        chk_tx(-100, 64);
        pop({1'b0, w1, w2});
        $display("t_src_off done");
    endtask
    task automatic t_tdm();
        pol = 1'b0;
        wr(8'h25, 8'h21);
        wr(8'h26, 8'h1F);
        i_host_link_model.send_frame(1'b0, 64, 31, 1'b0, w1, w2, 0);
        chk_tx(32, 64);
        pop({1'b0, w1, w2});
        $display("t_tdm done");
    endtask
    task automatic t_lj();
        fmt = sec_port_pkg::FMT_LJ;
        wr(8'h25, 8'h31);
        wr(8'h26, 8'h88);
        i_host_link_model.send_frame(1'b1, 72, 8, 1'b1, w1, w2, 0);
        chk_tx(104, 144);
        pop({1'b0, w1, w2});
        pop({1'b1, ~w1, ~w2});
        $display("t_lj done");
    endtask
    // i2s: frame opens on the right half, msb one bit after the sync edge
    task automatic t_i2s();
        fmt = sec_port_pkg::FMT_I2S;
        pol = 1'b1;
        wr(8'h25, 8'h21);
        wr(8'h26, 8'h83);
        i_host_link_model.send_frame(1'b1, 72, 3, 1'b0, w1, w2, 1);
        chk_tx(105, 144);
        pop({1'b1, w1, w2});
        pop({1'b0, ~w1, ~w2});
        $display("t_i2s done");
    endtask
    // internal clocks count outside controller mode too and are used only in it; stalled drain fills the fifo
    task automatic t_int();
        int n;
        fmt = sec_port_pkg::FMT_TDM;
        pol = 1'b0;
        i_host_link_model.hold(1'b1, 1'b0);
        wr(8'h26, 8'h60);
        repeat (1200) @(posedge clk);
        #1 chk(65'(rx_valid), 65'h0);
        n = 0;
        @(posedge bclk_int);
        while (bclk_int === 1'b1 && n < 100) begin
            @(posedge clk) #1;
            n++;
        end
        chk(65'(n), 65'h4);
        n = 0;
        @(posedge fsync_int);
        while (fsync_int === 1'b1 && n < 1000) begin
            @(posedge clk) #1;
            n++;
        end
        chk(65'(n), 65'h100);
        ctrl_mode = 1'b1;
        repeat (11000) @(posedge clk);
        #1 chk(65'(overrun), 65'h1);
        chk(rx_word, {1'b0, 32'hFFFF_FFFF, 32'h0000_0000});
        wr(8'h26, 8'h00);
        n = 0;
        rx_ready = 1'b1;
        repeat (40) begin
            if (rx_valid === 1'b1)
                n++;
            @(posedge clk) #1;
        end
        rx_ready = 1'b0;
        chk(65'(n), 65'h11);
        chk(65'(rx_valid), 65'h0);
        $display("t_int done");
    endtask
    task automatic test_done();
        $display("checks=%0d fails=%0d", total_checks, fails);
        if (fails == 0 && total_checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    initial begin
        #1_000_000;
        fails++;
        test_done();
    end
    initial begin
        repeat (6) @(posedge clk);
        #1 rst = 1'b0;
        t_regs();
        t_src_off();
        t_tdm();
        t_lj();
        t_i2s();
        t_int();
        test_done();
    end
endmodule
